/* File: hdl/pacl_defines.svh */
// Constants for the parallel asynchronous configuration loader
// Operation
// - Finished device drives chain output enable low
// - Enabled downstream device starts within one cycle
// - Ready/busy high outside own loading until user
// - Data pins high impedance outside own loading until user
// - Only loading device echoes busy on strobe
// - Wait shared done high before initializing
// - Error pulls status low; low status resets
// - Auto restart releases status within 40 us
// - Commonly enabled devices load identical broadcast stream
// - Selected only with high select, low select
// - Hold status low for power-on delay
// - Done line low until all but the last byte accepted
// - Reconfigure low in user mode restarts
// - After loading, pins follow user settings
// - Write edge captures byte, busy goes low
// - Status strobe low shows busy on bit7
// - Release done one byte before last
`ifndef PACL_DEFINES_SVH
`define PACL_DEFINES_SVH

`define PACL_CLK_HZ        50000000
`define PACL_TPOR_MS       12
`define PACL_TRESTART_US   40
`define PACL_TINIT_US      20
// Power-on hold, a least time, rounded up
`define PACL_POR_CYC       ((`PACL_TPOR_MS * `PACL_CLK_HZ + 999) / 1000)
// Restart time-out, a longest time, rounded down
`define PACL_RESTART_CYC   ((`PACL_TRESTART_US * `PACL_CLK_HZ) / 1000000)
// Done-high to user mode, a least time, rounded up
`define PACL_INIT_CYC      ((`PACL_TINIT_US * `PACL_CLK_HZ + 999999) / 1000000)
`define PACL_STREAM_BYTES  64
// Pin vector layout after the synchroniser
`define PACL_PIN_W         16
`define PACL_PIN_DATA_LSB  8
`define PACL_PIN_CFG       7
`define PACL_PIN_CE        6
`define PACL_PIN_CS        5
`define PACL_PIN_CSL       4
`define PACL_PIN_WS        3
`define PACL_PIN_RS        2
`define PACL_PIN_STATUS    1
`define PACL_PIN_DONE      0
`define PACL_PIN_RST       16'h00dc
`define PACL_ECHO_OE       8'h80

`endif

/* File: hdl/pacl_pkg.sv */
// Types for the parallel asynchronous configuration loader
package pacl_pkg;

    // Sequencer states, one-hot
    typedef enum logic [7:0] {
        pacl_st_por   = 8'h01,
        pacl_st_reset = 8'h02,
        pacl_st_wait  = 8'h04,
        pacl_st_load  = 8'h08,
        pacl_st_error = 8'h10,
        pacl_st_donew = 8'h20,
        pacl_st_init  = 8'h40,
        pacl_st_user  = 8'h80
    } pacl_state_e;

    // Whole state of the top level
    typedef struct packed {
        pacl_state_e st;
        logic [19:0] cnt;
        logic [23:0] bytes;
        logic        ws_prev;
        logic        status_oe;
        logic        done_oe;
        logic        od_val;
        logic        ceo_b;
        logic        rdy;
        logic        rdy_oe;
        logic [7:0]  dout;
        logic [7:0]  doe;
        logic        user;
    } pacl_top_s;

endpackage

/* File: hdl/pacl_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pacl_sync #(
    parameter int          W       = 16,
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] stable
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } pacl_sync_s;

    pacl_sync_s r;      // Registered state
    pacl_sync_s next_r; // Next state

    // Stage one feeds stage two only; a bit moves once stages two and three agree
    always_comb begin
        next_r        = r;
        next_r.s1     = pin;
        next_r.s2     = r.s1;
        next_r.s3     = r.s2;
        next_r.stable = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.stable);
    end

    // Synchronous reset to the idle pin levels
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            // Idle levels, so no false edge follows reset
            r.s1     <= RST_VAL[W-1:0];
            r.s2     <= RST_VAL[W-1:0];
            r.s3     <= RST_VAL[W-1:0];
            r.stable <= RST_VAL[W-1:0];
        end else begin
            r <= next_r;
        end
    end

    assign stable = r.stable;
endmodule

/* File: hdl/pacl_buf.sv */
// Two-entry skid buffer between byte capture and the consumer
`timescale 1ns/1ps
module pacl_buf #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    typedef struct packed {
        logic [W-1:0] d0;
        logic [W-1:0] d1;
        logic         v0;
        logic         v1;
    } pacl_buf_s;

    pacl_buf_s r;      // Registered state
    pacl_buf_s next_r; // Next state
    logic      push;   // Word accepted
    logic      pop;    // Word delivered

    // Head shifts on pop, new word lands in the first free slot
    always_comb begin
        next_r = r;
        push   = in_valid && !r.v1;
        pop    = r.v0 && out_ready;
        if (pop) begin
            next_r.d0 = r.d1;
            next_r.v0 = r.v1;
            next_r.v1 = 1'b0;
        end
        if (push) begin
            if (!next_r.v0) begin
                next_r.d0 = in_data;
                next_r.v0 = 1'b1;
            end else begin
                next_r.d1 = in_data;
                next_r.v1 = 1'b1;
            end
        end
        if (flush) begin
            next_r.v0 = 1'b0;
            next_r.v1 = 1'b0;
        end
    end

    // Register the state
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign in_ready  = !r.v1;
    assign out_valid = r.v0;
    assign out_data  = r.d0;
endmodule

/* File: hdl/pacl_top.sv */
// Configuration loader: chain hand-off, strobes, shared status and done lines
`timescale 1ns/1ps
`include "pacl_defines.svh"
module pacl_top #(
    parameter int POR_CYCLES   = `PACL_POR_CYC,
    parameter int STREAM_BYTES = `PACL_STREAM_BYTES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       reconfig_req_b,
    input  wire logic       chain_in_enable_b,
    output logic            chain_out_enable_b,
    input  wire logic       chip_select,
    input  wire logic       chip_select_low,
    input  wire logic       write_strobe_b,
    input  wire logic       status_read_strobe_b,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic      [7:0] data_oe,
    output logic            ready_busy_flag,
    output logic            ready_busy_oe,
    input  wire logic       status_in,
    output logic            status_out,
    output logic            status_oe,
    input  wire logic       done_in,
    output logic            done_out,
    output logic            done_oe,
    input  wire logic       auto_restart_en,
    input  wire logic [7:0] user_data_out,
    input  wire logic [7:0] user_data_oe,
    input  wire logic       user_rdy_out,
    input  wire logic       user_rdy_oe,
    output logic            user_mode,
    output logic      [7:0] cfg_byte,
    output logic            cfg_byte_valid,
    input  wire logic       cfg_byte_ready
);
    import pacl_pkg::*;

    localparam int RESTART_CYC = `PACL_RESTART_CYC; // Error hold under auto restart
    localparam int INIT_CYC    = `PACL_INIT_CYC;    // Done-high to user mode

    pacl_top_s                  r;        // Registered state
    pacl_top_s                  next_r;   // Next state
    logic [`PACL_PIN_W-1:0]     pins;     // Filtered pin levels
    logic                       cfg_s;    // Reconfigure request, high = released
    logic                       ce_on;    // Chain enable active
    logic                       sel;      // Chip selected
    logic                       ws_s;     // Write strobe level
    logic                       rs_on;    // Status read strobe active
    logic                       status_s; // Shared status line
    logic                       done_s;   // Shared done line
    logic                       ws_rise;  // Write strobe rising edge
    logic                       push_req; // Byte offered to the buffer
    logic                       overrun;  // Byte arrived while buffer full
    logic                       buf_rdy;  // Buffer has room
    logic                       flush;    // Drop buffered bytes
    logic                       abort;    // Reconfigure request or shared status low
    logic [23:0]                bytes_nx; // Byte count after this capture

    // All configuration pins are asynchronous to the internal clock
    pacl_sync #(
        .W       (`PACL_PIN_W),
        .RST_VAL (`PACL_PIN_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     ({data_in, reconfig_req_b, chain_in_enable_b, chip_select, chip_select_low,
                   write_strobe_b, status_read_strobe_b, status_in, done_in}),
        .stable  (pins)
    );

    // Decoded pin levels
    always_comb begin
        cfg_s    = pins[`PACL_PIN_CFG];
        ce_on    = !pins[`PACL_PIN_CE];
        sel      = pins[`PACL_PIN_CS] && !pins[`PACL_PIN_CSL];
        ws_s     = pins[`PACL_PIN_WS];
        rs_on    = !pins[`PACL_PIN_RS];
        status_s = pins[`PACL_PIN_STATUS];
        done_s   = pins[`PACL_PIN_DONE];
    end

    // Byte capture only while loading and selected; idle devices never see strobes
    always_comb begin
        ws_rise  = ws_s && !r.ws_prev;
        push_req = ws_rise && sel && (r.st == pacl_st_load);
        overrun  = push_req && !buf_rdy;
        flush    = (r.st == pacl_st_reset) || (r.st == pacl_st_error) || (r.st == pacl_st_por);
        abort    = !cfg_s || !status_s;
        bytes_nx = r.bytes + 24'h000001;
    end

    // Two-entry buffer so a stalled consumer does not lose a byte
    pacl_buf #(
        .W (8)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .flush     (flush),
        .in_valid  (push_req),
        .in_ready  (buf_rdy),
        .in_data   (pins[`PACL_PIN_W-1:`PACL_PIN_DATA_LSB]),
        .out_valid (cfg_byte_valid),
        .out_ready (cfg_byte_ready),
        .out_data  (cfg_byte)
    );

    // Sequencer and registered pin drive
    always_comb begin
        next_r         = r;
        next_r.ws_prev = ws_s;
        next_r.od_val  = 1'b0;
        unique case (r.st)
            pacl_st_por: begin
                // Hold status and done low for the whole power-on delay
                next_r.status_oe = 1'b1;
                next_r.done_oe   = 1'b1;
                next_r.cnt       = r.cnt + 20'h00001;
                if (r.cnt >= 20'(POR_CYCLES - 1)) begin
                    next_r.st  = pacl_st_reset;
                    next_r.cnt = '0;
                end
            end
            pacl_st_reset: begin
                // Status follows the request; shared line must come high before loading
                next_r.status_oe = !cfg_s;
                next_r.done_oe   = 1'b1;
                next_r.ceo_b     = 1'b1;
                next_r.bytes     = '0;
                next_r.cnt       = '0;
                if (cfg_s && status_s) begin
                    next_r.st = pacl_st_wait;
                end
            end
            pacl_st_wait: begin
                // Go within one cycle of chain enable; a common enable gives broadcast
                if (abort) begin
                    next_r.st = pacl_st_reset;
                end else if (ce_on) begin
                    next_r.st = pacl_st_load;
                end
            end
            pacl_st_load: begin
                if (abort) begin
                    next_r.st = pacl_st_reset;
                end else if (overrun) begin
                    // Byte written while the buffer is full: flag an error on the shared line
                    next_r.st        = pacl_st_error;
                    next_r.status_oe = 1'b1;
                    next_r.cnt       = '0;
                end else if (push_req) begin
                    next_r.bytes = bytes_nx;
                    if (bytes_nx >= 24'(STREAM_BYTES - 1)) begin
                        next_r.done_oe = 1'b0;
                    end
                    if (bytes_nx >= 24'(STREAM_BYTES)) begin
                        // Pass the bus to the next device in the chain
                        next_r.st    = pacl_st_donew;
                        next_r.ceo_b = 1'b0;
                    end
                end
            end
            pacl_st_error: begin
                next_r.status_oe = 1'b1;
                if (!cfg_s) begin
                    next_r.st = pacl_st_reset;
                end else if (auto_restart_en) begin
                    // Release after the restart time-out; host then resends
                    next_r.cnt = r.cnt + 20'h00001;
                    if (r.cnt >= 20'(RESTART_CYC - 1)) begin
                        next_r.st        = pacl_st_reset;
                        next_r.status_oe = 1'b0;
                    end
                end
            end
            pacl_st_donew: begin
                // The whole chain initialises together once every device released done
                if (abort) begin
                    next_r.st = pacl_st_reset;
                end else if (done_s) begin
                    next_r.st  = pacl_st_init;
                    next_r.cnt = '0;
                end
            end
            pacl_st_init: begin
                next_r.cnt = r.cnt + 20'h00001;
                if (abort) begin
                    next_r.st = pacl_st_reset;
                end else if (r.cnt >= 20'(INIT_CYC - 1)) begin
                    next_r.st = pacl_st_user;
                end
            end
            pacl_st_user: begin
                // A low request restarts configuration from user mode
                if (!cfg_s) begin
                    next_r.st = pacl_st_reset;
                end
            end
            default: begin
                next_r.st = pacl_st_reset;
            end
        endcase

        // Entering reset drives done low and chain output enable high at once
        if (next_r.st == pacl_st_reset && r.st != pacl_st_reset) begin
            next_r.done_oe = 1'b1;
            next_r.ceo_b   = 1'b1;
        end

        // Ready/busy, data and user pins follow the next state
        next_r.user = (next_r.st == pacl_st_user);
        next_r.dout = '0;
        next_r.doe  = '0;
        if (next_r.st == pacl_st_user) begin
            // Dual-purpose pins hand over to user logic
            next_r.rdy    = user_rdy_out;
            next_r.rdy_oe = user_rdy_oe;
            next_r.dout   = user_data_out;
            next_r.doe    = user_data_oe;
        end else if (next_r.st == pacl_st_load) begin
            // Busy while a byte is captured or still buffered
            next_r.rdy    = !(push_req || cfg_byte_valid);
            next_r.rdy_oe = 1'b1;
            if (rs_on) begin
                next_r.dout[7] = next_r.rdy;
                next_r.doe     = `PACL_ECHO_OE;
            end
        end else begin
            // Other devices keep the shared bus free and the busy AND high
            next_r.rdy    = 1'b1;
            next_r.rdy_oe = 1'b1;
            next_r.doe    = '0;
        end
    end

    // Register the state; reset enters the power-on hold
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            r           <= '0;
            r.st        <= pacl_st_por;
            r.status_oe <= 1'b1;
            r.done_oe   <= 1'b1;
            r.ceo_b     <= 1'b1;
            r.ws_prev   <= 1'b1;
            r.rdy       <= 1'b1;
            r.rdy_oe    <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    assign chain_out_enable_b = r.ceo_b;
    assign data_out           = r.dout;
    assign data_oe            = r.doe;
    assign ready_busy_flag    = r.rdy;
    assign ready_busy_oe      = r.rdy_oe;
    assign status_out         = r.od_val;
    assign status_oe          = r.status_oe;
    assign done_out           = r.od_val;
    assign done_oe            = r.done_oe;
    assign user_mode          = r.user;

    // Checks on the sequencer
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Counter that tracks the hold time in the error state
    // Cleared while auto restart is off, since then the hold has no bound
    logic [19:0] err_age; // Cycles spent in error with auto restart
    always_ff @(posedge clk_sys) begin
        if (!rst_b || r.st != pacl_st_error || !auto_restart_en) begin
            err_age <= '0;
        end else begin
            err_age <= err_age + 20'h00001;
        end
    end

    a_chain_handoff: assert property (
        $fell(chain_out_enable_b) |-> $past(r.st) == pacl_st_load && r.bytes == 24'(STREAM_BYTES))
        else $error("chain output enabled before stream completed");

    a_start_prompt: assert property (
        (r.st == pacl_st_wait && ce_on && !abort) |=> r.st == pacl_st_load)
        else $error("enabled device did not start loading next cycle");

    a_busy_idle_high: assert property (
        (r.st != pacl_st_load && r.st != pacl_st_user) |-> ready_busy_flag && ready_busy_oe)
        else $error("ready/busy not high outside loading");

    a_bus_hiz: assert property (
        (r.st != pacl_st_load && r.st != pacl_st_user) |-> data_oe == 8'h00)
        else $error("data bus driven outside loading");

    a_busy_echo: assert property (
        (data_oe != 8'h00 && !user_mode) |-> r.st == pacl_st_load && data_oe == 8'h80
            && data_out[7] == ready_busy_flag)
        else $error("busy echo wrong or from idle device");

    a_init_waits_done: assert property (
        $rose(r.st == pacl_st_init) |-> $past(done_s) && !done_oe)
        else $error("initialisation began before shared done high");

    a_error_pulls: assert property (
        (overrun && cfg_s && status_s) |=> status_oe ##1 status_oe)
        else $error("error did not pull status low");

    a_restart_bound: assert property (
        (auto_restart_en && r.st == pacl_st_error) |-> err_age < 20'(RESTART_CYC))
        else $error("status held past restart time-out");

    a_por_hold: assert property (
        (r.st == pacl_st_por) |-> status_oe && done_oe)
        else $error("status or done released during power-on");

    a_done_early: assert property (
        (r.st == pacl_st_load && r.bytes < 24'(STREAM_BYTES - 1)) |-> done_oe)
        else $error("done released too early");

    a_user_restart: assert property (
        (r.st == pacl_st_user && !cfg_s) |=> r.st == pacl_st_reset && done_oe)
        else $error("reconfigure request ignored in user mode");

    // An accepted byte that keeps the device loading must show busy next cycle
    a_busy_capture: assert property (
        (push_req && !overrun && !abort && bytes_nx < 24'(STREAM_BYTES)) |=> !ready_busy_flag)
        else $error("ready/busy not low after byte capture");

    // In user mode the pins carry the user values of the cycle before
    a_user_pins: assert property (
        user_mode |-> data_oe == $past(user_data_oe) && data_out == $past(user_data_out)
            && ready_busy_oe == $past(user_rdy_oe))
        else $error("user pins not handed to user logic");

    // Main scenarios: user mode, error, status poll, full buffer, auto release
    c_reach_user:  cover property ($rose(user_mode));
    c_error_seen:  cover property ($rose(r.st == pacl_st_error));
    c_status_read: cover property ($rose(data_oe[7]) && !user_mode);
    c_buffer_full: cover property (push_req && !buf_rdy);
    c_auto_release: cover property ($fell(status_oe) && $past(r.st) == pacl_st_error);
endmodule

/* File: bench/pacl_host.sv */
// Host model: drives configuration strobes, select and data
`timescale 1ns/1ps
module pacl_host (
    input  wire logic       clk_sys,
    output logic            write_strobe_b,
    output logic            status_read_strobe_b,
    output logic            chip_select,
    output logic      [7:0] data
);
    // Idle: strobes high, selected
    initial begin
        write_strobe_b = 1'b1;
        status_read_strobe_b = 1'b1;
        chip_select = 1'b1;
        data = 8'h00;
    end
    // One byte; select and data held well past the rising edge
    task automatic wr(input logic [7:0] d, input logic sel);
        @(posedge clk_sys) begin
            write_strobe_b <= 1'b0;
            chip_select <= sel;
            data <= d;
        end
        repeat (6) @(posedge clk_sys);
        write_strobe_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        data <= ~d; // Inverted, so the old byte is not kept
        #1; // Caller samples off the edge
    endtask
    // Status poll; host keeps off bit 7 meanwhile
    task automatic rd();
        @(posedge clk_sys) status_read_strobe_b <= 1'b0;
        repeat (10) @(posedge clk_sys);
        status_read_strobe_b <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1; // Caller samples off the edge
    endtask
endmodule

/* File: bench/test_parallel_async_config_chain.sv */
// Testbench for the configuration loader
`timescale 1ns/1ps
module test_parallel_async_config_chain;
    import pacl_pkg::*;
    logic       clk_sys;           // 50 MHz clock
    logic       rst_b;             // Sync reset
    logic       reconfig_req_b;    // Reconfigure request
    logic       chain_in_enable_b; // Chain enable in
    logic       auto_restart_en;   // Restart option
    logic       cfg_byte_ready;    // Consumer ready
    logic       csl;               // Active-low select
    logic [7:0] u_oe;              // User pin enables
    logic       ceo_b, ws_b, rs_b, cs, rb, rb_oe, st_o, st_oe, dn_o, dn_oe, um, cv;
    logic [7:0] hd, dout, doe, cb;
    int         err_total, compares, cyc;
    // Open-drain lines with pull-ups; bit 7 shared with the echo
    wire        st_w = st_oe ? st_o : 1'b1;
    wire        dn_w = dn_oe ? dn_o : 1'b1;
    wire  [7:0] din = (doe & dout) | (~doe & hd);
    pacl_host host (.clk_sys(clk_sys), .write_strobe_b(ws_b), .status_read_strobe_b(rs_b),
        .chip_select(cs), .data(hd));
    pacl_top #(.POR_CYCLES(16), .STREAM_BYTES(4)) DUT (.clk_sys(clk_sys), .rst_b(rst_b),
        .reconfig_req_b(reconfig_req_b), .chain_in_enable_b(chain_in_enable_b),
        .chain_out_enable_b(ceo_b), .chip_select(cs), .chip_select_low(csl),
        .write_strobe_b(ws_b), .status_read_strobe_b(rs_b), .data_in(din),
        .data_out(dout), .data_oe(doe), .ready_busy_flag(rb), .ready_busy_oe(rb_oe),
        .status_in(st_w), .status_out(st_o), .status_oe(st_oe), .done_in(dn_w),
        .done_out(dn_o), .done_oe(dn_oe), .auto_restart_en(auto_restart_en),
        .user_data_out(8'h5a), .user_data_oe(u_oe), .user_rdy_out(1'b1),
        .user_rdy_oe(1'b0), .user_mode(um), .cfg_byte(cb), .cfg_byte_valid(cv),
        .cfg_byte_ready(cfg_byte_ready));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Hang guard, well above the expected run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 12000) begin
            err_total++;
            stop_test();
        end
    end
    // Compare one value
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Let a number of edges pass, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Idle pins after power-on hold
    task automatic t_por();
        chk("status_oe", st_oe, 1);
        chk("done_oe", dn_oe, 1);
        w(40);
        chk("ceo", ceo_b, 1);
        chk("rdy", rb, 1);
        chk("data_oe", doe, 0);
        $display("t_por done");
    endtask
    // Ignored strobes, then a full stream with stall and poll
    task automatic t_load();
        host.wr(8'h11, 1'b1);
        chk("valid", cv, 0);
        @(posedge clk_sys);
        chain_in_enable_b <= 1'b0;
        w(8);
        host.wr(8'h22, 1'b0);
        chk("valid", cv, 0);
        @(posedge clk_sys);
        csl <= 1'b1;
        host.wr(8'h33, 1'b1);
        chk("valid", cv, 0);
        @(posedge clk_sys);
        csl <= 1'b0;
        host.wr(8'ha5, 1'b1);
        chk("busy", rb, 0);
        chk("byte", cb, 8'ha5);
        fork
            host.rd();
            begin
                w(8);
                chk("echo_oe", doe, 8'h80);
                chk("echo", dout[7], 0);
            end
        join
        @(posedge clk_sys);
        cfg_byte_ready <= 1'b1;
        host.wr(8'h01, 1'b1);
        host.wr(8'h02, 1'b1);
        chk("done_oe", dn_oe, 0);
        chk("ceo", ceo_b, 1);
        host.wr(8'h03, 1'b1);
        chk("ceo", ceo_b, 0);
        chk("rdy", rb, 1);
        chk("user", um, 0);
        w(1100);
        chk("user", um, 1);
        chk("data_oe", doe, 8'h3c);
        chk("user_dout", dout, 8'h5a);
        chk("rdy_oe", rb_oe, 0);
        @(posedge clk_sys);
        u_oe <= 8'hc3;
        w(2);
        chk("data_oe", doe, 8'hc3);
        $display("t_load done");
    endtask
    // Three bytes into a stalled consumer overrun the two-entry buffer
    task automatic ovf();
        host.wr(8'h0f, 1'b1);
        host.wr(8'hf0, 1'b1);
        host.wr(8'h3c, 1'b1);
    endtask
    // Reconfigure from user mode, overflow without and with auto restart, resend
    task automatic t_err();
        int n;
        @(posedge clk_sys);
        reconfig_req_b <= 1'b0;
        w(10);
        chk("user", um, 0);
        chk("done_oe", dn_oe, 1);
        @(posedge clk_sys);
        reconfig_req_b <= 1'b1;
        cfg_byte_ready <= 1'b0;
        w(20);
        ovf();
        chk("status_oe", st_oe, 1);
        chk("status_out", st_o, 0);
        w(2100);
        chk("held", st_oe, 1);
        @(posedge clk_sys);
        reconfig_req_b <= 1'b0;
        w(2000);
        @(posedge clk_sys);
        reconfig_req_b <= 1'b1;
        auto_restart_en <= 1'b1;
        w(20);
        chk("status_oe", st_oe, 0);
        ovf();
        n = 0;
        while (st_oe === 1'b1 && n < 2100) begin
            w(1);
            n++;
        end
        chk("released", n < 2100, 1);
        w(10);
        @(posedge clk_sys);
        cfg_byte_ready <= 1'b1;
        host.wr(8'h01, 1'b1);
        host.wr(8'h02, 1'b1);
        host.wr(8'h03, 1'b1);
        host.wr(8'h04, 1'b1);
        chk("ceo", ceo_b, 0);
        $display("t_err done");
    endtask
    // Verdict
    task automatic stop_test();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        reconfig_req_b = 1'b1;
        chain_in_enable_b = 1'b1;
        auto_restart_en = 1'b0;
        cfg_byte_ready = 1'b0;
        csl = 1'b0;
        u_oe = 8'h3c;
        err_total = 0;
        compares = 0;
        cyc = 0;
        w(5);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        w(2);
        t_por();
        t_load();
        t_err();
        stop_test();
    end
endmodule
